// ### hdl/tgmc_divider.sv
// two-stage prescaler and twenty-one-stage divider
`timescale 1ns/1ps
`default_nettype none
module tgmc_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic clr,
    input wire logic pre_tick,
    input wire logic s7_low,
    input wire logic lf_tick,
    output logic [tgmc_pkg::DIV_STAGES-1:0] div_q
);
    // ========================================================
    // ripple chain modelled as carries of synchronous counters
    logic [tgmc_pkg::PRE_STAGES-1:0] pre_q;
    wire pre_carry = pre_tick && (&pre_q);
    wire low_carry = pre_carry && (&div_q[tgmc_pkg::DIV_LOW_STAGES-1:0]);
    // stage seven takes either the stage six carry or the slow clock
    wire s7_in = s7_low ? lf_tick : low_carry;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
            div_q <= '0;
        end else if (ce) begin
            if (clr) begin
                pre_q <= '0;
                div_q <= '0;
            end else begin
                if (pre_tick) begin
                    pre_q <= pre_q + 2'h1;
                end
                if (pre_carry) begin
                    div_q[5:0] <= div_q[5:0] + 6'h01;
                end
                if (s7_in) begin
                    div_q[20:6] <= div_q[20:6] + 15'h0001;
                end
            end
        end
    end
endmodule : tgmc_divider
`default_nettype wire

// ### hdl/tgmc_mcycle.sv
// machine cycle state counter, four states per cycle
`timescale 1ns/1ps
`default_nettype none
module tgmc_mcycle (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic run,
    input wire logic tick,
    output logic [1:0] state_q,
    output logic cycle_end
);
    // ========================================================
    // one state per main clock period, wraps after the last
    assign cycle_end = run && tick && (state_q == tgmc_pkg::MC_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= 2'h0;
        end else if (ce && run && tick) begin
            state_q <= state_q + 2'h1;
        end
    end
endmodule : tgmc_mcycle
`default_nettype wire

// ### hdl/tgmc_pkg.sv
// shared constants and types of the timing generator and mode controller
package tgmc_pkg;
    // ========================================================
    // apb register map
    localparam logic [7:0] ADDR_SYSCTL = 8'h00;
    localparam logic [7:0] ADDR_TBCTL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DIVIDER = 8'h0C;
    // system_control_two field positions and reset value
    localparam int SC_HIGH_OSC = 7;
    localparam int SC_LOW_OSC = 6;
    localparam int SC_CPU_CLK = 5;
    localparam int SC_IDLE = 4;
    localparam int SC_TG_HALT = 2;
    localparam logic [7:0] SYSCTL_RESET = 8'h80;
    // timebase_control field positions and reset value
    localparam int TB_SRC_LSB = 0;
    localparam int TB_ENABLE = 3;
    localparam int TB_DIV7_SEL = 4;
    localparam logic [7:0] TBCTL_RESET = 8'h00;
    // status field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_MCSTATE_LSB = 12;
    localparam int ST_TBLATCH = 14;
    // ========================================================
    // divider geometry
    localparam int PRE_STAGES = 2;
    localparam int DIV_STAGES = 21;
    localparam int DIV_LOW_STAGES = 6;
    localparam int MC_STATES = 4;
    localparam logic [1:0] MC_LAST = 2'h3;
    // divider bit watched by the time base for each source select value
    localparam int TB_TAP [8] = '{20, 18, 13, 11, 10, 9, 8, 6};
    // ========================================================
    // operating modes, one-hot
    typedef enum logic [11:0] {
        RUN_FAST_SINGLE = 12'h001,
        HALT_CPU_SINGLE = 12'h002,
        DEEP_HALT_FAST = 12'h004,
        RUN_FAST_DUAL = 12'h008,
        HALT_CPU_DUAL = 12'h010,
        RUN_SLOW_OSC_ON = 12'h020,
        RUN_SLOW_OSC_OFF = 12'h040,
        HALT_SLOW_OSC_ON = 12'h080,
        HALT_SLOW_OSC_OFF = 12'h100,
        DEEP_HALT_SLOW = 12'h200,
        STOP_HALT = 12'h400,
        STOP_WARM = 12'h800
    } tgmc_mode_e;
    // clock and power gating handed to the consumers
    typedef struct packed {
        logic cpu_run;
        logic wdt_run;
        logic periph_run;
        logic tbt_run;
        logic high_osc_on;
        logic low_osc_on;
        logic low_pins_port;
    } tgmc_gate_s;
endpackage : tgmc_pkg

// ### hdl/tgmc_top.sv
// timing generator and operating mode controller with apb registers
//
// Overview of operation
// (R1) prescaler and divider cleared on reset, stop entry and stop release
// (R2) two-stage prescaler feeds twenty-one-stage divider, plus main clock and cycle counter
// (R3) stage seven input chosen by mode, cpu clock select and divider seven select
// (R4) software never sets divider seven select in single-clock mode
// (R5) software sets divider seven select only after slow oscillator is stable
// (R6) slow and slow-halt modes force slow clock into stage seven
// (R7) warm-up after stop from fast run feeds stage six into stage seven
// (R8) machine cycle is four states, each one main clock period
// (R9) single-clock mode: only fast oscillator, crystal pins are ports, four fast periods
// (R10) reset enters single-clock fast run
// (R11) idle bit halts cpu and watchdog; any interrupt returns to fast run
// (R12) on idle release, master enable chooses interrupt entry or next instruction
// (R13) deep idle gates all but time base; selected tap falling edge wakes
// (R14) deep idle returns to fast run; time-base latch set if enabled at entry
// (R15) dual mode: fast modes use fast clock, slow modes use slow clock
// (R16) software enables slow oscillator at start to use dual mode
// (R17) cpu clock select switches fast and slow run; clearing fast osc enters osc-off slow
// (R18) software keeps slow oscillator enabled during slow run with both oscillators
// (R19) slow osc-off run and sleep modes stop clock into stage one
// (R20) dual idle halts cpu and watchdog, returns to dual fast run
// (R21) slow halt runs peripherals on slow clock, returns to slow run
// (R22) deep sleep gates like deep idle, wakes on tap edge, returns to osc-off slow
`timescale 1ns/1ps
`default_nettype none
module tgmc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic high_freq_clock,
    input wire logic low_freq_clock,
    input wire logic irq_request,
    input wire logic interrupt_master_enable,
    input wire logic timebase_irq_individual_enable,
    input wire logic timebase_irq_ack,
    input wire logic stop_enter,
    input wire logic stop_return_slow,
    input wire logic stop_release,
    input wire logic warmup_done,
    output tgmc_pkg::tgmc_gate_s gate,
    output logic main_clk_tick,
    output logic [1:0] mc_state,
    output logic mc_cycle_end,
    output logic [tgmc_pkg::DIV_STAGES-1:0] divider_value,
    output logic resume_accept_irq,
    output logic resume_next_instr,
    output logic timebase_irq_latch,
    output logic timebase_irq_take
);
    // ========================================================
    // register bus decode
    logic [7:0] sysctl_q;
    logic [7:0] tbctl_q;
    tgmc_pkg::tgmc_mode_e mode_q;
    tgmc_pkg::tgmc_mode_e mode_d;
    logic from_fast_q;
    logic ten_entry_q;
    logic tap_prev_q;
    logic [31:0] rdata_w;

    wire acc = psel && penable;
    wire hit_sys = (paddr == tgmc_pkg::ADDR_SYSCTL);
    wire hit_tb = (paddr == tgmc_pkg::ADDR_TBCTL);
    wire hit_st = (paddr == tgmc_pkg::ADDR_STATUS);
    wire hit_div = (paddr == tgmc_pkg::ADDR_DIVIDER);
    wire hit_any = hit_sys || hit_tb || hit_st || hit_div;
    wire wr_sys = acc && pwrite && hit_sys;
    wire wr_tb = acc && pwrite && hit_tb;

    // zero wait states; status and divider are read only
    assign pready = 1'b1;
    assign pslverr = acc && (!hit_any || (pwrite && (hit_st || hit_div)));
    assign rdata_w = hit_sys ? {24'h000000, sysctl_q} :
                     hit_tb ? {24'h000000, tbctl_q} :
                     hit_st ? {17'h00000, timebase_irq_latch, mc_state, mode_q} :
                     hit_div ? {11'h000, divider_value} : 32'h00000000;

    // ========================================================
    // control bits
    wire high_osc_enable = sysctl_q[tgmc_pkg::SC_HIGH_OSC];
    wire low_osc_enable = sysctl_q[tgmc_pkg::SC_LOW_OSC];
    wire cpu_clock_select = sysctl_q[tgmc_pkg::SC_CPU_CLK];
    wire idle_bit = sysctl_q[tgmc_pkg::SC_IDLE];
    wire timing_gen_halt_enable = sysctl_q[tgmc_pkg::SC_TG_HALT];
    wire [2:0] timebase_source_select = tbctl_q[tgmc_pkg::TB_SRC_LSB +: 3];
    wire timebase_enable = tbctl_q[tgmc_pkg::TB_ENABLE];
    wire divider7_source_select = tbctl_q[tgmc_pkg::TB_DIV7_SEL];

    // ========================================================
    // mode groups
    wire in_fast = (mode_q == tgmc_pkg::RUN_FAST_SINGLE) ||
                   (mode_q == tgmc_pkg::HALT_CPU_SINGLE) ||
                   (mode_q == tgmc_pkg::DEEP_HALT_FAST) ||
                   (mode_q == tgmc_pkg::RUN_FAST_DUAL) ||
                   (mode_q == tgmc_pkg::HALT_CPU_DUAL);
    wire in_slow = (mode_q == tgmc_pkg::RUN_SLOW_OSC_ON) ||
                   (mode_q == tgmc_pkg::RUN_SLOW_OSC_OFF) ||
                   (mode_q == tgmc_pkg::HALT_SLOW_OSC_ON) ||
                   (mode_q == tgmc_pkg::HALT_SLOW_OSC_OFF) ||
                   (mode_q == tgmc_pkg::DEEP_HALT_SLOW);
    wire in_deep = (mode_q == tgmc_pkg::DEEP_HALT_FAST) ||
                   (mode_q == tgmc_pkg::DEEP_HALT_SLOW);
    wire in_halt = (mode_q == tgmc_pkg::HALT_CPU_SINGLE) ||
                   (mode_q == tgmc_pkg::HALT_CPU_DUAL) ||
                   (mode_q == tgmc_pkg::HALT_SLOW_OSC_ON) ||
                   (mode_q == tgmc_pkg::HALT_SLOW_OSC_OFF);
    wire in_stop = (mode_q == tgmc_pkg::STOP_HALT) || (mode_q == tgmc_pkg::STOP_WARM);
    wire fast_osc_off = (mode_q == tgmc_pkg::RUN_SLOW_OSC_OFF) ||
                        (mode_q == tgmc_pkg::HALT_SLOW_OSC_OFF) ||
                        (mode_q == tgmc_pkg::DEEP_HALT_SLOW) ||
                        (mode_q == tgmc_pkg::STOP_HALT);
    wire single_clk = !low_osc_enable && !in_slow;

    // ========================================================
    // divider chain
    // (R6) (R7) (R3) stage seven source
    wire warm_fast = (mode_q == tgmc_pkg::STOP_WARM) && from_fast_q;
    // (R19) stage one clock stopped; runs in warm-up after fast stop
    wire pre_tick = high_freq_clock && (warm_fast || (!fast_osc_off && !in_slow && !in_stop));
    wire s7_low = in_slow ? 1'b1 : (warm_fast ? 1'b0 : divider7_source_select);
    wire lf_tick = low_freq_clock && !(mode_q == tgmc_pkg::STOP_HALT);
    // (R1) clear on stop entry and release
    wire enter_stop = (mode_d == tgmc_pkg::STOP_HALT) && (mode_q != tgmc_pkg::STOP_HALT);
    wire leave_stop = (mode_q == tgmc_pkg::STOP_HALT) && (mode_d != tgmc_pkg::STOP_HALT);
    wire div_clr = enter_stop || leave_stop;

    // (R2) prescaler and divider
    tgmc_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clr(div_clr),
        .pre_tick(pre_tick),
        .s7_low(s7_low),
        .lf_tick(lf_tick),
        .div_q(divider_value)
    );

    // ========================================================
    // main clock and machine cycle
    // (R9) (R15) fast clock in fast modes, slow clock in slow modes
    assign main_clk_tick = in_fast ? high_freq_clock : (in_slow ? low_freq_clock : 1'b0);

    // (R8) four states per machine cycle
    tgmc_mcycle u_mc (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .run(gate.cpu_run),
        .tick(main_clk_tick),
        .state_q(mc_state),
        .cycle_end(mc_cycle_end)
    );

    // ========================================================
    // wake sources
    wire tap_now = divider_value[tgmc_pkg::TB_TAP[timebase_source_select]];
    wire tb_fall = tap_prev_q && !tap_now;
    wire halt_wake = in_halt && irq_request;
    // (R13) (R22) tap falling edge ends deep halts
    wire deep_wake = in_deep && tb_fall;
    // (R12) interrupt entry or next instruction
    assign resume_accept_irq = halt_wake && interrupt_master_enable;
    assign resume_next_instr = halt_wake && !interrupt_master_enable;
    wire idle_clr = halt_wake || deep_wake;

    // ========================================================
    // mode sequencer
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            tgmc_pkg::RUN_FAST_SINGLE, tgmc_pkg::RUN_FAST_DUAL: begin
                if (stop_enter) begin
                    mode_d = tgmc_pkg::STOP_HALT;
                // (R11) (R13) idle entry
                end else if (idle_bit) begin
                    mode_d = timing_gen_halt_enable ? tgmc_pkg::DEEP_HALT_FAST :
                             (single_clk ? tgmc_pkg::HALT_CPU_SINGLE :
                             tgmc_pkg::HALT_CPU_DUAL);
                // (R17) switch to slow run
                end else if (cpu_clock_select && low_osc_enable) begin
                    mode_d = tgmc_pkg::RUN_SLOW_OSC_ON;
                end else begin
                    mode_d = single_clk ? tgmc_pkg::RUN_FAST_SINGLE :
                             tgmc_pkg::RUN_FAST_DUAL;
                end
            end
            tgmc_pkg::RUN_SLOW_OSC_ON: begin
                if (stop_enter) begin
                    mode_d = tgmc_pkg::STOP_HALT;
                end else if (idle_bit) begin
                    mode_d = timing_gen_halt_enable ? tgmc_pkg::DEEP_HALT_SLOW :
                             tgmc_pkg::HALT_SLOW_OSC_ON;
                // (R17) back to fast, or fast oscillator off
                end else if (!cpu_clock_select) begin
                    mode_d = tgmc_pkg::RUN_FAST_DUAL;
                end else if (!high_osc_enable) begin
                    mode_d = tgmc_pkg::RUN_SLOW_OSC_OFF;
                end
            end
            tgmc_pkg::RUN_SLOW_OSC_OFF: begin
                if (stop_enter) begin
                    mode_d = tgmc_pkg::STOP_HALT;
                end else if (idle_bit) begin
                    mode_d = timing_gen_halt_enable ? tgmc_pkg::DEEP_HALT_SLOW :
                             tgmc_pkg::HALT_SLOW_OSC_OFF;
                end else if (high_osc_enable) begin
                    mode_d = tgmc_pkg::RUN_SLOW_OSC_ON;
                end
            end
            // (R11) (R20) (R21) interrupt returns to the run mode
            tgmc_pkg::HALT_CPU_SINGLE: begin
                if (irq_request) begin
                    mode_d = tgmc_pkg::RUN_FAST_SINGLE;
                end
            end
            tgmc_pkg::HALT_CPU_DUAL: begin
                if (irq_request) begin
                    mode_d = tgmc_pkg::RUN_FAST_DUAL;
                end
            end
            tgmc_pkg::HALT_SLOW_OSC_ON: begin
                if (irq_request) begin
                    mode_d = tgmc_pkg::RUN_SLOW_OSC_ON;
                end
            end
            tgmc_pkg::HALT_SLOW_OSC_OFF: begin
                if (irq_request) begin
                    mode_d = tgmc_pkg::RUN_SLOW_OSC_OFF;
                end
            end
            // (R14) (R22) deep halts return to fixed run modes
            tgmc_pkg::DEEP_HALT_FAST: begin
                if (tb_fall) begin
                    mode_d = tgmc_pkg::RUN_FAST_SINGLE;
                end
            end
            tgmc_pkg::DEEP_HALT_SLOW: begin
                if (tb_fall) begin
                    mode_d = tgmc_pkg::RUN_SLOW_OSC_OFF;
                end
            end
            tgmc_pkg::STOP_HALT: begin
                if (stop_release) begin
                    mode_d = tgmc_pkg::STOP_WARM;
                end
            end
            tgmc_pkg::STOP_WARM: begin
                if (warmup_done) begin
                    mode_d = stop_return_slow ? tgmc_pkg::RUN_SLOW_OSC_OFF :
                             tgmc_pkg::RUN_FAST_SINGLE;
                end
            end
            default: begin
                mode_d = tgmc_pkg::RUN_FAST_SINGLE;
            end
        endcase
    end

    // ========================================================
    // state registers
    // (R10) reset lands in single-clock fast run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= tgmc_pkg::RUN_FAST_SINGLE;
            from_fast_q <= 1'b0;
            ten_entry_q <= 1'b0;
            tap_prev_q <= 1'b0;
        end else if (ce) begin
            mode_q <= mode_d;
            tap_prev_q <= div_clr ? 1'b0 : tap_now;
            if (enter_stop) begin
                from_fast_q <= in_fast;
            end
            if (!in_deep) begin
                ten_entry_q <= timebase_enable;
            end
        end
    end

    // software writes win over the hardware idle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysctl_q <= tgmc_pkg::SYSCTL_RESET;
            tbctl_q <= tgmc_pkg::TBCTL_RESET;
        end else if (ce) begin
            if (wr_sys) begin
                sysctl_q <= pwdata[7:0];
            end else if (idle_clr) begin
                sysctl_q[tgmc_pkg::SC_IDLE] <= 1'b0;
            end
            if (wr_tb) begin
                tbctl_q <= pwdata[7:0];
            end
        end
    end

    // (R14) latch set on deep exit, set wins over ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timebase_irq_latch <= 1'b0;
        end else if (ce) begin
            if (deep_wake && ten_entry_q) begin
                timebase_irq_latch <= 1'b1;
            end else if (timebase_irq_ack) begin
                timebase_irq_latch <= 1'b0;
            end
        end
    end
    assign timebase_irq_take = timebase_irq_latch && interrupt_master_enable &&
                               timebase_irq_individual_enable && timebase_enable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= rdata_w;
        end
    end

    // ========================================================
    // gating outputs
    // (R9) (R11) (R13) (R20) (R21) consumer gating per mode
    assign gate.cpu_run = (mode_q == tgmc_pkg::RUN_FAST_SINGLE) ||
                          (mode_q == tgmc_pkg::RUN_FAST_DUAL) ||
                          (mode_q == tgmc_pkg::RUN_SLOW_OSC_ON) ||
                          (mode_q == tgmc_pkg::RUN_SLOW_OSC_OFF);
    assign gate.wdt_run = gate.cpu_run;
    assign gate.periph_run = gate.cpu_run || in_halt;
    assign gate.tbt_run = gate.periph_run || in_deep;
    assign gate.high_osc_on = !fast_osc_off;
    assign gate.low_osc_on = !single_clk && (mode_q != tgmc_pkg::STOP_HALT);
    assign gate.low_pins_port = single_clk;

    // ========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    stop_clear_a: assert property (ce && enter_stop |=> divider_value == '0) // (R1)
        else $error("divider not cleared on stop entry");
    slow_s7_a: assert property (in_slow |-> s7_low) // (R6)
        else $error("slow mode not feeding slow clock to stage seven");
    warm_s7_a: assert property (warm_fast |-> !s7_low) // (R7)
        else $error("warm-up from fast run not feeding stage six");
    pre_stop_a: assert property (fast_osc_off || in_slow |-> !pre_tick) // (R19)
        else $error("prescaler clocked while stage one stopped");
    main_src_a: assert property (in_fast |-> main_clk_tick == high_freq_clock) // (R15)
        else $error("fast mode main clock not from fast clock");
    mc_wrap_a: assert property (ce && mc_cycle_end |=> mc_state == 2'h0) // (R8)
        else $error("machine cycle did not wrap after four states");
    idle_enter_a: assert property (ce && mode_q == tgmc_pkg::RUN_FAST_SINGLE && idle_bit
        && !timing_gen_halt_enable && !stop_enter && single_clk
        |=> mode_q == tgmc_pkg::HALT_CPU_SINGLE && !gate.cpu_run && gate.periph_run) // (R11)
        else $error("idle entry did not halt cpu only");
    deep_wake_a: assert property (ce && mode_q == tgmc_pkg::DEEP_HALT_FAST && tb_fall
        |=> mode_q == tgmc_pkg::RUN_FAST_SINGLE && gate.periph_run) // (R13)
        else $error("deep idle did not wake to fast run");
    tb_latch_a: assert property (ce && deep_wake && ten_entry_q |=> timebase_irq_latch) // (R14)
        else $error("time base latch not set after deep exit");
    sleep_ret_a: assert property (ce && mode_q == tgmc_pkg::DEEP_HALT_SLOW && tb_fall
        |=> mode_q == tgmc_pkg::RUN_SLOW_OSC_OFF ##0 !gate.high_osc_on) // (R22)
        else $error("deep sleep did not return to osc-off slow run");

    idle_wake_c: cover property (in_halt ##1 halt_wake ##1 gate.cpu_run);
    deep_wake_c: cover property (in_deep ##1 deep_wake);
    stop_cycle_c: cover property (enter_stop ##[1:50] leave_stop);
    slow_run_c: cover property (mode_q == tgmc_pkg::RUN_SLOW_OSC_OFF);
endmodule : tgmc_top
`default_nettype wire

// ### tb/tb_timing_gen_mode_control.sv
// self-checking testbench of the timing generator and mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_timing_gen_mode_control;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, hf, lf, irq, ack, main_tick, mc_end, acc, nxt, latch, take, e;
    logic ime = 1'b0, ind = 1'b0, wake = 1'b0, stp = 1'b0, rel = 1'b0;
    logic [1:0] mc_state;
    logic [20:0] divv;
    tgmc_pkg::tgmc_gate_s gate;
    int miscompares = 0, total_checks = 0;
    always #2.5 pclk = ~pclk;
    tgmc_partner far (.pclk(pclk), .presetn(presetn), .wake(wake), .gate(gate), .take(take),
        .hf_tick(hf), .lf_tick(lf), .irq(irq), .ack(ack));
    tgmc_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_freq_clock(hf), .low_freq_clock(lf), .irq_request(irq),
        .interrupt_master_enable(ime), .timebase_irq_individual_enable(ind),
        .timebase_irq_ack(ack), .stop_enter(stp), .stop_return_slow(1'b0),
        .stop_release(rel), .warmup_done(rel), .gate(gate), .main_clk_tick(main_tick),
        .mc_state(mc_state), .mc_cycle_end(mc_end), .divider_value(divv),
        .resume_accept_irq(acc), .resume_next_instr(nxt), .timebase_irq_latch(latch),
        .timebase_irq_take(take));
    task complete_run;
        if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task chk(input string n, input logic [31:0] x, input logic [31:0] s);
        total_checks++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    // ========================================================
    // apb master: setup, then access until pready at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task mode_is(input tgmc_pkg::tgmc_mode_e m);
        apb(1'b0, tgmc_pkg::ADDR_STATUS, 32'h0);
        chk("mode", 32'(m), {20'h0, r[11:0]});
    endtask : mode_is
    // cycle ends counted over a span; exact whatever the phase
    task ends(input int cyc, input int x);
        int n, t;
        logic [1:0] s;
        n = 0;
        t = 0;
        @(negedge pclk);
        s = mc_state;
        repeat (cyc) begin
            if (mc_end === 1'b1) n++;
            if (main_tick === 1'b1) t++;
            @(negedge pclk);
        end
        chk("cycle_ends", x, n);
        chk("main_ticks", 4 * x, t);
        chk("mc_state", 2'(s + t), mc_state);
    endtask : ends
    task t_stop;
        stp <= 1'b1;
        @(posedge pclk);
        stp <= 1'b0;
        mode_is(tgmc_pkg::STOP_HALT);
        chk("divider", 0, divv);
        rel <= 1'b1;
        @(posedge pclk);
        rel <= 1'b0;
        mode_is(tgmc_pkg::STOP_WARM);
        repeat (300) @(posedge pclk);
        chk("stage_seven", 1, divv[20:6]);
        rel <= 1'b1;
        @(posedge pclk);
        rel <= 1'b0;
        mode_is(tgmc_pkg::RUN_FAST_SINGLE);
    endtask : t_stop
    // ========================================================
    task t_idle(input logic m);
        int n;
        n = 0;
        apb(1'b1, tgmc_pkg::ADDR_SYSCTL, 32'h90);
        mode_is(tgmc_pkg::HALT_CPU_SINGLE);
        chk("cpu_run", 0, gate.cpu_run);
        ime <= m;
        wake <= 1'b1;
        do begin
            @(negedge pclk);
            n++;
        end while (acc !== 1'b1 && nxt !== 1'b1 && n < 20);
        chk("accept", m, acc);
        chk("next", !m, nxt);
        wake <= 1'b0;
        mode_is(tgmc_pkg::RUN_FAST_SINGLE);
    endtask : t_idle
    task t_deep;
        int n;
        n = 0;
        apb(1'b1, tgmc_pkg::ADDR_TBCTL, 32'h0F);
        apb(1'b1, tgmc_pkg::ADDR_SYSCTL, 32'h94);
        mode_is(tgmc_pkg::DEEP_HALT_FAST);
        chk("gates", 32'h1, {gate.periph_run, gate.tbt_run});
        do begin
            @(negedge pclk);
            n++;
        end while (gate.cpu_run !== 1'b1 && n < 2000);
        mode_is(tgmc_pkg::RUN_FAST_SINGLE);
        chk("latch", 1, latch);
        ime <= 1'b1;
        ind <= 1'b1;
        repeat (4) @(negedge pclk);
        chk("latch", 0, latch);
    endtask : t_deep
    task t_slow;
        // low oscillator enabled first, divider seven select left clear
        apb(1'b1, tgmc_pkg::ADDR_SYSCTL, 32'hC0);
        mode_is(tgmc_pkg::RUN_FAST_DUAL);
        chk("pins", 0, gate.low_pins_port);
        apb(1'b1, tgmc_pkg::ADDR_SYSCTL, 32'hE0);
        mode_is(tgmc_pkg::RUN_SLOW_OSC_ON);
        ends(160, 5);
        apb(1'b1, tgmc_pkg::ADDR_SYSCTL, 32'h60);
        mode_is(tgmc_pkg::RUN_SLOW_OSC_OFF);
        chk("gate", 32'h7A, gate);
        r = {26'h0, divv[5:0]};
        repeat (40) @(negedge pclk);
        chk("low_stages", r, {26'h0, divv[5:0]});
    endtask : t_slow
    initial begin
        #200000;
        miscompares++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge pclk);
        chk("divider", 0, divv);
        presetn <= 1'b1;
        apb(1'b0, tgmc_pkg::ADDR_SYSCTL, 32'h0);
        chk("sysctl", 32'h80, r);
        mode_is(tgmc_pkg::RUN_FAST_SINGLE);
        chk("pins", 1, gate.low_pins_port);
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", 1, e);
        ends(40, 10);
        t_idle(1'b1);
        t_idle(1'b0);
        t_stop;
        t_deep;
        t_slow;
        complete_run;
    end
endmodule : tb_timing_gen_mode_control
`default_nettype wire

// ### tb/tgmc_partner.sv
// clock sources and interrupt source facing the mode controller
`timescale 1ns/1ps
`default_nettype none
module tgmc_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wake,
    input wire tgmc_pkg::tgmc_gate_s gate,
    input wire logic take,
    output logic hf_tick,
    output logic lf_tick,
    output logic irq,
    output logic ack
);
    logic [2:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'h0;
            irq <= 1'b0;
            ack <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            // request held only while the core is halted
            irq <= wake & ~gate.cpu_run;
            ack <= take & ~ack;
        end
    end
    // fast tick every cycle, slow tick one cycle in eight
    assign hf_tick = presetn;
    assign lf_tick = (cnt_q == 3'h7);
endmodule : tgmc_partner
`default_nettype wire
